// [hw/ljh_limit_judge.sv]
`timescale 1ns/1ns
module ljh_limit_judge
	import ljh_pkg::*;
#(
	parameter int AVG_MAX = AVG_SPAN
)(
	input  wire logic               ref_clk,
	input  wire logic               srst,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic signed [31:0] sampleValue,
	input  wire logic               sampleValid,
	input  wire logic               holdButton,
	input  wire logic               extHold,
	input  wire logic               escapeButton,
	input  wire logic               extClear,
	input  wire logic               judgeIn,
	output logic                    upperOuterFlag,
	output logic                    upperInnerFlag,
	output logic                    lowerInnerFlag,
	output logic                    lowerOuterFlag,
	output logic signed [31:0]      displayValue,
	output logic      [1:0]         barZeroPos,
	output logic                    holdActive
);
	localparam logic [CNT_W-1:0] AVG_LIM = CNT_W'(AVG_MAX);

	// One judgment step with the shared width applied on the release edge
	function automatic logic judgeStep(input logic prev, input logic signed [31:0] v,
		input logic signed [31:0] lim, input logic signed [31:0] hy, input logic above);
		logic signed [32:0] ve;
		logic signed [32:0] le;
		logic signed [32:0] he;
		ve = {v[31], v};
		le = {lim[31], lim};
		he = {hy[31], hy};
		if (above)
			judgeStep = prev ? (ve > le - he) : (ve > le);
		else
			judgeStep = prev ? (ve < le + he) : (ve < le);
	endfunction

	logic [CTRL_W-1:0]   ctrl_q;
	logic signed [31:0]  limUo_q;
	logic signed [31:0]  limUi_q;
	logic signed [31:0]  limLi_q;
	logic signed [31:0]  limLx_q;
	logic signed [31:0]  hyst_q;
	logic [NPIN-1:0]     syncA_q;
	logic [NPIN-1:0]     syncB_q;
	logic [NPIN-1:0]     syncC_q;
	ljh_state_t          state_q;
	ljh_state_t          state_d;
	logic signed [31:0]  last_q;
	logic signed [31:0]  max_q;
	logic signed [31:0]  min_q;
	logic signed [47:0]  sum_q;
	logic [CNT_W-1:0]    cnt_q;
	logic signed [31:0]  kept_q;
	logic [3:0]          raw_q;
	logic [7:0]          addr_q;
	logic                wr_q;
	logic                judgeTick_q;

	// Control fields
	wire [2:0]       patSel   = ctrl_q[C_PAT +: 3];
	wire             areaMode = ctrl_q[C_AREA];
	wire             gateEn   = ctrl_q[C_GATE];
	wire             outerEn  = ctrl_q[C_OUTER];
	wire             barAuto  = ctrl_q[C_BAR];
	wire ljh_hmode_t hMode    = ljh_hmode_t'(ctrl_q[C_HMODE +: 3]);
	wire             extPulse = ctrl_q[C_EXTP];
	wire             zoneDef  = ctrl_q[C_ZONE];
	wire             clearEn  = ctrl_q[C_CLREN];

	// Two-stage synchronisers; edges compare the second stage with a third delay stage
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			syncA_q <= '0;
			syncB_q <= '0;
			syncC_q <= '0;
		end
		else
		begin
			syncA_q <= {judgeIn, extClear, escapeButton, extHold, holdButton};
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
		end
	end

	// Pin events as single-cycle pulses
	wire [NPIN-1:0] rise = syncB_q & ~syncC_q;
	wire [NPIN-1:0] fall = ~syncB_q & syncC_q;
	wire holdToggle = rise[IN_HBTN] | (extPulse & rise[IN_XHOLD]);
	wire holdOnLvl  = ~extPulse & rise[IN_XHOLD];
	wire holdOffLvl = ~extPulse & fall[IN_XHOLD];
	wire sampleMode = (hMode == HM_SAMPLE);
	wire clrEv      = clearEn & ~sampleMode & (rise[IN_CBTN] | rise[IN_XCLR]);
	wire avgFull    = (hMode == HM_AVG) && (cnt_q >= AVG_LIM);
	wire running    = (state_q == ST_RUN);
	wire startEv    = ~running & (hMode != HM_NONE) & (holdToggle | holdOnLvl);
	wire stopEv     = running & (holdToggle | holdOffLvl | avgFull);
	wire restart    = startEv | (running & clrEv & ~stopEv);

	// Hold result for the selected mode
	wire signed [47:0] avgVal = sum_q / $signed({32'h0000_0000, cnt_q});
	logic signed [31:0] result;
	always_comb
	begin
		case (hMode)
			HM_SAMPLE: result = max_q;
			HM_PEAK:   result = max_q;
			HM_PB:     result = max_q;
			HM_BOTTOM: result = min_q;
			HM_AVG:    result = avgVal[31:0];
			HM_SPAN:   result = max_q - min_q;
			default:   result = last_q;
		endcase
	end

	// Hold sequencer; sample mode never enters the kept state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (startEv)
					state_d = ST_RUN;
			ST_RUN:
				if (hMode == HM_NONE)
					state_d = ST_IDLE;
				else if (stopEv)
					state_d = (zoneDef && !sampleMode) ? ST_KEPT : ST_IDLE;
			ST_KEPT:
				if (startEv)
					state_d = ST_RUN;
				else if (clrEv)
					state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	wire signed [31:0] dispD = (state_q == ST_RUN) ? result :
		(state_q == ST_KEPT) ? kept_q : last_q;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			kept_q  <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (running && state_d == ST_KEPT)
				kept_q <= result;
		end
	end

	// Trackers step once per sample; a restart reloads from the latest sample
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			last_q <= '0;
			max_q  <= '0;
			min_q  <= '0;
			sum_q  <= '0;
			cnt_q  <= '0;
			judgeTick_q <= 1'b0;
		end
		else
		begin
			judgeTick_q <= sampleValid;
			if (sampleValid)
				last_q <= sampleValue;
			if (restart)
			begin
				max_q <= last_q;
				min_q <= last_q;
				sum_q <= 48'(last_q);
				cnt_q <= CNT_W'(1);
			end
			else if (running && sampleValid && !sampleMode && !avgFull)
			begin
				if (sampleValue > max_q)
					max_q <= sampleValue;
				if (sampleValue < min_q)
					min_q <= sampleValue;
				sum_q <= sum_q + 48'(sampleValue);
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	// Raw judgment states, bit 3..0 = upper outer, upper inner, lower inner, lower outer
	// Judged one edge after the strobe, so the flags follow the new sample, not the one before it
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			raw_q <= '0;
		else if (judgeTick_q)
		begin
			raw_q[3] <= outerEn & judgeStep(raw_q[3], dispD, limUo_q, hyst_q, patSel <= 3'h3);
			raw_q[2] <= judgeStep(raw_q[2], dispD, limUi_q, hyst_q, patSel <= 3'h2);
			raw_q[1] <= judgeStep(raw_q[1], dispD, limLi_q, hyst_q, patSel <= 3'h1);
			raw_q[0] <= outerEn & judgeStep(raw_q[0], dispD, limLx_q, hyst_q, patSel == 3'h0);
		end
	end

	// Output shaping: area pattern masks inner flags beyond the outer limits
	wire gateOpen = ~gateEn | syncB_q[IN_JUDGE];
	wire uoOut = raw_q[3] & outerEn;
	wire lxOut = raw_q[0] & outerEn;
	wire uiOut = areaMode ? (raw_q[2] & ~raw_q[3]) : raw_q[2];
	wire liOut = areaMode ? (raw_q[1] & ~raw_q[0]) : raw_q[1];
	wire [1:0] barAutoPos = ((outerEn ? limLx_q : limLi_q) >= 0) ? BAR_LEFT :
		((outerEn ? limUo_q : limUi_q) <= 0) ? BAR_RIGHT : BAR_CENTRE;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			upperOuterFlag <= 1'b0;
			upperInnerFlag <= 1'b0;
			lowerInnerFlag <= 1'b0;
			lowerOuterFlag <= 1'b0;
			displayValue   <= '0;
			barZeroPos     <= BAR_LEFT;
			holdActive     <= 1'b0;
		end
		else
		begin
			upperOuterFlag <= gateOpen & uoOut;
			upperInnerFlag <= gateOpen & uiOut;
			lowerInnerFlag <= gateOpen & liOut;
			lowerOuterFlag <= gateOpen & lxOut;
			displayValue   <= dispD;
			barZeroPos     <= barAuto ? barAutoPos : BAR_LEFT;
			holdActive     <= (state_d == ST_RUN);
		end
	end

	// AHB-Lite slave, zero wait states; sizes below a word are treated as a word
	wire aPhase = hsel & hready & htrans[1];
	wire [31:0] statusWord = {24'h0, state_q, barZeroPos, upperOuterFlag, upperInnerFlag,
		lowerInnerFlag, lowerOuterFlag};
	wire [31:0] rdMux =
		(haddr[7:0] == OFS_CTRL)   ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
		(haddr[7:0] == OFS_LIM_UO) ? limUo_q :
		(haddr[7:0] == OFS_LIM_UI) ? limUi_q :
		(haddr[7:0] == OFS_LIM_LI) ? limLi_q :
		(haddr[7:0] == OFS_LIM_LX) ? limLx_q :
		(haddr[7:0] == OFS_HYST)   ? hyst_q :
		(haddr[7:0] == OFS_STATUS) ? statusWord :
		(haddr[7:0] == OFS_DISP)   ? displayValue : 32'h0000_0000;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			addr_q    <= '0;
			wr_q      <= 1'b0;
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			wr_q <= aPhase & hwrite & (haddr[31:8] == 24'h0);
			if (aPhase)
				addr_q <= haddr[7:0];
			if (aPhase && !hwrite)
				hrdata <= (haddr[31:8] == 24'h0) ? rdMux : 32'h0000_0000;
		end
	end

	// Data-phase register writes; unmapped offsets are dropped
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ctrl_q  <= CTRL_RST;
			limUo_q <= LIM_UO_RST;
			limUi_q <= LIM_UI_RST;
			limLi_q <= LIM_LI_RST;
			limLx_q <= LIM_LX_RST;
			hyst_q  <= HYST_RST;
		end
		else if (wr_q)
		begin
			case (addr_q)
				OFS_CTRL:   ctrl_q  <= hwdata[CTRL_W-1:0];
				OFS_LIM_UO: limUo_q <= hwdata;
				OFS_LIM_UI: limUi_q <= hwdata;
				OFS_LIM_LI: limLi_q <= hwdata;
				OFS_LIM_LX: limLx_q <= hwdata;
				OFS_HYST:   hyst_q  <= hwdata;
				default:    ;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_judge_gate_closed:
	assert property (gateEn && !syncB_q[IN_JUDGE] |=> !upperOuterFlag && !upperInnerFlag
		&& !lowerInnerFlag && !lowerOuterFlag) else $error("flag driven while judge gate closed");
	a_outer_off_quiet:
	assert property (!outerEn |=> !upperOuterFlag && !lowerOuterFlag)
		else $error("outer flag with outer limits disabled");
	a_area_inner_excl:
	assert property (areaMode |=> !(upperInnerFlag && upperOuterFlag) && !(lowerInnerFlag && lowerOuterFlag))
		else $error("area pattern inner and outer flag together");
	a_uo_set_above:
	assert property (judgeTick_q && outerEn && patSel <= 3'h3 && dispD > limUo_q |=> raw_q[3])
		else $error("upper outer flag not set above limit");
	a_uo_release_edge:
	assert property (judgeTick_q && raw_q[3] && patSel <= 3'h3
		&& $signed({dispD[31], dispD}) <= $signed({limUo_q[31], limUo_q}) - $signed({hyst_q[31], hyst_q})
		|=> !raw_q[3])
		else $error("upper outer flag not released at limit minus width");
	a_li_hold_band:
	assert property (judgeTick_q && raw_q[1] && patSel >= 3'h2
		&& $signed({dispD[31], dispD}) < $signed({limLi_q[31], limLi_q}) + $signed({hyst_q[31], hyst_q})
		|=> raw_q[1])
		else $error("lower inner flag released inside hysteresis band");
	a_sample_no_clear:
	assert property (sampleMode && running && (rise[IN_CBTN] || rise[IN_XCLR]) && !stopEv
		|=> state_q == ST_RUN && max_q == $past(max_q))
		else $error("sample hold disturbed by clear");
	a_avg_span_end:
	assert property (running && hMode == HM_AVG && cnt_q >= AVG_LIM |=> state_q != ST_RUN)
		else $error("average hold ran past its span");
	a_kept_until_clear:
	assert property (state_q == ST_KEPT && !clrEv && !startEv |=> state_q == ST_KEPT && displayValue == kept_q)
		else $error("kept result lost without clear");
	a_peak_tracks_max:
	assert property (running && hMode == HM_PEAK && sampleValid && !restart |=> max_q >= $past(sampleValue))
		else $error("peak hold missed a larger sample");
endmodule

// [hw/ljh_pkg.sv]
package ljh_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LIM_UO = 8'h04;
	localparam logic [7:0] OFS_LIM_UI = 8'h08;
	localparam logic [7:0] OFS_LIM_LI = 8'h0C;
	localparam logic [7:0] OFS_LIM_LX = 8'h10;
	localparam logic [7:0] OFS_HYST   = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_DISP   = 8'h1C;
	// Control word field positions
	localparam int C_PAT   = 0;
	localparam int C_AREA  = 3;
	localparam int C_GATE  = 4;
	localparam int C_OUTER = 5;
	localparam int C_BAR   = 6;
	localparam int C_HMODE = 7;
	localparam int C_EXTP  = 10;
	localparam int C_ZONE  = 11;
	localparam int C_CLREN = 12;
	localparam int CTRL_W  = 13;
	// Pass position 2 (two limits each side), outer limits on, clear enabled
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h1022;
	localparam logic [31:0] LIM_UO_RST = 32'h0000_0FA0;
	localparam logic [31:0] LIM_UI_RST = 32'h0000_0BB8;
	localparam logic [31:0] LIM_LI_RST = 32'h0000_03E8;
	localparam logic [31:0] LIM_LX_RST = 32'h0000_0000;
	localparam logic [31:0] HYST_RST   = 32'h0000_0000;
	// Synchronised pin indices
	localparam int IN_HBTN  = 0;
	localparam int IN_XHOLD = 1;
	localparam int IN_CBTN  = 2;
	localparam int IN_XCLR  = 3;
	localparam int IN_JUDGE = 4;
	localparam int NPIN     = 5;
	// Averaging sample counter width and default span
	localparam int CNT_W       = 16;
	localparam int AVG_SPAN    = 20000;
	typedef enum logic [2:0] {
		HM_NONE   = 3'h0,
		HM_SAMPLE = 3'h1,
		HM_PEAK   = 3'h2,
		HM_BOTTOM = 3'h3,
		HM_AVG    = 3'h4,
		HM_SPAN   = 3'h5,
		HM_PB     = 3'h6
	} ljh_hmode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN  = 2'h1,
		ST_KEPT = 2'h3
	} ljh_state_t;
	localparam logic [1:0] BAR_LEFT   = 2'h0;
	localparam logic [1:0] BAR_CENTRE = 2'h1;
	localparam logic [1:0] BAR_RIGHT  = 2'h2;
endpackage

// [verification/ljh_src_model.sv]
`timescale 1ns/1ns
module ljh_src_model(
	input  wire logic               ref_clk,
	input  wire logic               go,
	input  wire logic signed [31:0] value,
	output logic signed [31:0]      sampleValue,
	output logic                    sampleValid
);
	// One-cycle strobe per sample; the word is junk outside it so a stale reuse shows up
	always_ff @(posedge ref_clk)
	begin
		sampleValid <= go;
		sampleValue <= go ? value : ~value;
	end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench
	import ljh_pkg::*;
;
	localparam logic signed [31:0] LIM_A = LIM_UO_RST, LIM_B = LIM_UI_RST, LIM_C = LIM_LI_RST, LIM_D = LIM_LX_RST;
	logic               refClk, srst, hsel, hwrite, hready, hreadyout, hresp, go, sampleValid, holdActive;
	logic               uo, ui, li, lx;
	logic [1:0]         htrans, barZeroPos;
	logic [2:0]         hsize;
	logic [3:0]         st;
	logic [4:0]         pins;
	logic [31:0]        haddr, hwdata, hrdata, lfsr, rd;
	logic signed [31:0] value, sampleValue, displayValue, ex;
	int                 nErrors, comparisons;
	logic [31:0]        cf [7] = '{32'h1022, 32'h102A, 32'h1032, 32'h1032, 32'h1022, 32'h1020, 32'h1002};
	logic signed [31:0] cv [12] = '{4001, 3950, 3900, 3001, 2950, 2900, 999, 1050, 1100, -1, 50, 100};

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	ljh_src_model i_ljh_src_model(.ref_clk(refClk), .go(go), .value(value), .sampleValue(sampleValue),
		.sampleValid(sampleValid));
	ljh_limit_judge #(.AVG_MAX(8)) i_ljh_limit_judge(.ref_clk(refClk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sampleValue(sampleValue), .sampleValid(sampleValid),
		.holdButton(pins[IN_HBTN]), .extHold(pins[IN_XHOLD]), .escapeButton(pins[IN_CBTN]),
		.extClear(pins[IN_XCLR]), .judgeIn(pins[IN_JUDGE]), .upperOuterFlag(uo), .upperInnerFlag(ui),
		.lowerInnerFlag(li), .lowerOuterFlag(lx), .displayValue(displayValue), .barZeroPos(barZeroPos),
		.holdActive(holdActive));

	// 125 MHz clock
	initial
	begin
		refClk = 1'b0;
		forever #4 refClk = ~refClk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("Mismatches %0d, comparisons %0d", nErrors, comparisons);
		if (nErrors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Bounded wait for ready; a hung slave ends the run
	task automatic waitRdy();
		int n;
		n = 0;
		do
		begin
			@(posedge refClk);
			n++;
		end
		while (hready !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			nErrors++;
			results();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= 3'h2;
		htrans <= 2'h2;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
		check("hresp", 32'(hresp), 32'h0);
	endtask

	// Pipeline is fixed: strobe, take, flags and display settle well inside five edges
	task automatic smp(input logic signed [31:0] v);
		value <= v;
		go <= 1'b1;
		@(posedge refClk);
		go <= 1'b0;
		repeat (5) @(posedge refClk);
	endtask

	// Pins pass two sync stages and an edge detector, so each level stays six clocks
	task automatic pin(input int k, input logic v);
		pins[k] <= v;
		repeat (6) @(posedge refClk);
	endtask

	task automatic press(input int k);
		pin(k, 1'b1);
		pin(k, 1'b0);
	endtask

	function automatic logic signed [31:0] rnd(input int span, input int off);
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return $signed(lfsr % span) + off;
	endfunction

	function automatic logic [31:0] hc(input logic [2:0] m, input logic z, input logic p);
		return 32'(CTRL_RST) | {20'h0, z, p, m, 7'h0};
	endfunction

	// Flag state model; boundaries at or above the pass position fire upward and release downward
	task automatic upd(input logic signed [31:0] v, input logic signed [31:0] h, input int p);
		logic signed [31:0] lim [4];
		lim = '{LIM_D, LIM_C, LIM_B, LIM_A};
		for (int j = 0; j < 4; j++)
			st[j] = j >= p ? (v > lim[j]) | (st[j] & (v > lim[j] - h))
				: (v < lim[j]) | (st[j] & (v < lim[j] + h));
	endtask

	function automatic logic [3:0] expf(input logic [31:0] c, input logic j);
		logic [3:0] e;
		e = st;
		if (c[C_AREA])
			e = {st[3], st[2] & ~st[3], st[1] & ~st[0], st[0]};
		if (!c[C_OUTER])
			e = e & 4'h6;
		if (c[C_GATE] && !j)
			e = 4'h0;
		return e;
	endfunction

	task automatic track(input logic isMax);
		logic signed [31:0] v;
		for (int i = 0; i < 8; i++)
		begin
			v = rnd(4000, -2000);
			ex = isMax ? (v > ex ? v : ex) : (v < ex ? v : ex);
			smp(v);
			check("tracked", displayValue, ex);
		end
	endtask

	task automatic barChk(input logic [1:0] e);
		repeat (3) @(posedge refClk);
		check("bar", {30'h0, barZeroPos}, {30'h0, e});
	endtask

	// Main sequence
	initial
	begin
		logic signed [31:0] v;
		int hy;
		srst = 1'b1;
		{hsel, hwrite, go} = 3'h0;
		{haddr, hwdata, value} = '0;
		htrans = 2'h0;
		hsize = 3'h2;
		pins = 5'h0;
		lfsr = 32'hA02DA3C3;
		st = 4'h0;
		nErrors = 0;
		comparisons = 0;
		repeat (12) @(posedge refClk);
		srst <= 1'b0;
		@(posedge refClk);
		check("flags", 32'({uo, ui, li, lx}), 32'h0);
		bus(1'b1, 8'h20, 32'hFFFF_FFFF);
		for (int i = 0; i < 7; i++)
		begin
			bus(1'b0, i < 6 ? 8'(4 * i) : 8'h20, 32'h0);
			check("regreset", rd, i == 0 ? 32'(CTRL_RST) : i == 1 ? LIM_UO_RST : i == 2 ? LIM_UI_RST :
				i == 3 ? LIM_LI_RST : i == 4 ? LIM_LX_RST : i == 5 ? HYST_RST : 32'h0);
		end
		for (int m = 0; m < 7; m++)
		begin
			bus(1'b1, OFS_CTRL, hc(3'(m), 1'b0, 1'b0));
			bus(1'b0, OFS_CTRL, 32'h0);
			check("mode", rd, hc(3'(m), 1'b0, 1'b0));
		end
		for (int i = 0; i < 7; i++)
		begin
			hy = (i == 4 || i == 6) ? 0 : 100;
			bus(1'b1, OFS_CTRL, cf[i]);
			bus(1'b1, OFS_HYST, 32'(hy));
			pin(IN_JUDGE, i != 2);
			for (int k = 0; k < 24; k++)
			begin
				v = k < 12 ? cv[k] : rnd(5000, -500);
				upd(v, hy, int'(cf[i][2:0]));
				smp(v);
				check("flags", 32'({uo, ui, li, lx}), 32'(expf(cf[i], i != 2)));
			end
		end
		bus(1'b1, OFS_CTRL, 32'h1062);
		barChk(BAR_LEFT);
		bus(1'b1, OFS_LIM_LX, 32'hFFFF_FFF6);
		barChk(BAR_CENTRE);
		bus(1'b1, OFS_LIM_UO, 32'h0);
		bus(1'b1, OFS_LIM_UI, 32'hFFFF_FFFB);
		bus(1'b1, OFS_LIM_LI, 32'hFFFF_FFF8);
		barChk(BAR_RIGHT);
		bus(1'b1, OFS_CTRL, 32'h1022);
		barChk(BAR_LEFT);
		// Peak by button, clear mid-run, live display after end
		bus(1'b1, OFS_CTRL, hc(HM_PEAK, 1'b0, 1'b0));
		smp(100);
		press(IN_HBTN);
		check("active", 32'(holdActive), 32'h1);
		ex = 100;
		track(1'b1);
		press(IN_CBTN);
		ex = value;
		check("cleared", displayValue, ex);
		track(1'b1);
		press(IN_HBTN);
		check("active", 32'(holdActive), 32'h0);
		check("live", displayValue, value);
		// Bottom on external level with the result kept until clear
		bus(1'b1, OFS_CTRL, hc(HM_BOTTOM, 1'b1, 1'b0));
		pin(IN_XHOLD, 1'b1);
		check("active", 32'(holdActive), 32'h1);
		ex = value;
		track(1'b0);
		pin(IN_XHOLD, 1'b0);
		check("active", 32'(holdActive), 32'h0);
		smp(1234);
		check("kept", displayValue, ex);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status", {30'h0, rd[7:6]}, 32'h3);
		bus(1'b0, OFS_DISP, 32'h0);
		check("disp", rd, ex);
		press(IN_XCLR);
		check("live", displayValue, 32'sd1234);
		// External hold in pulse form toggles
		bus(1'b1, OFS_CTRL, hc(HM_PEAK, 1'b0, 1'b1));
		press(IN_XHOLD);
		check("active", 32'(holdActive), 32'h1);
		press(IN_XHOLD);
		check("active", 32'(holdActive), 32'h0);
		// Sample hold ignores clear and zone
		bus(1'b1, OFS_CTRL, hc(HM_SAMPLE, 1'b1, 1'b0));
		smp(77);
		press(IN_HBTN);
		smp(555);
		check("frozen", displayValue, 32'sd77);
		press(IN_CBTN);
		check("frozen", displayValue, 32'sd77);
		press(IN_HBTN);
		check("active", 32'(holdActive), 32'h0);
		check("live", displayValue, 32'sd555);
		// Average stops by itself at the span and keeps its value
		bus(1'b1, OFS_CTRL, hc(HM_AVG, 1'b1, 1'b0));
		smp(600);
		press(IN_HBTN);
		smp(700);
		smp(800);
		smp(900);
		check("average", displayValue, 32'sd750);
		check("active", 32'(holdActive), 32'h1);
		repeat (9) smp(600);
		check("active", 32'(holdActive), 32'h0);
		check("average", displayValue, 32'sd675);
		// Reset while the average is kept drops it and clears the hold output, the four flags and the display
		srst <= 1'b1;
		repeat (2) @(posedge refClk);
		srst <= 1'b0;
		@(posedge refClk);
		check("reset", 32'({holdActive, uo, ui, li, lx}), 32'h0);
		check("reset", displayValue, 32'h0);
		bus(1'b0, OFS_CTRL, 32'h0);
		check("regreset", rd, 32'(CTRL_RST));
		results();
	end
endmodule
